// file: verilog/dsci_pkg.sv
// constants and types shared by the ddr command interface
package dsci_pkg;

	// ****************************************
	// command codes: {select, row, column, write} strobes, active low
	// ****************************************
	localparam int CMD_W = 4;
	localparam logic [CMD_W-1:0] CMD_MODE_LOAD = 4'h0;
	localparam logic [CMD_W-1:0] CMD_REFRESH = 4'h1;
	localparam logic [CMD_W-1:0] CMD_PRECHARGE = 4'h2;
	localparam logic [CMD_W-1:0] CMD_ACTIVATE = 4'h3;
	localparam logic [CMD_W-1:0] CMD_WRITE = 4'h4;
	localparam logic [CMD_W-1:0] CMD_READ = 4'h5;
	localparam logic [CMD_W-1:0] CMD_STOP = 4'h6;
	localparam logic [CMD_W-1:0] CMD_NOP = 4'h7;

	// ****************************************
	// widths and array shape
	// ****************************************
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int DQ_W = 16;
	localparam int LANE_W = 8;
	localparam int NUM_LANES = 2;
	localparam int COL_W = 3;
	localparam int IDX_W = BANK_W + 1 + COL_W;
	localparam int MEM_DEPTH = 64;
	localparam int PTR_W = 2;
	localparam int PAIR_SLOTS = 4;
	localparam int LEFT_W = 3;
	localparam int REFCNT_W = 16;

	// ****************************************
	// address fields and mode register layout
	// ****************************************
	localparam int AP_BIT = 10;
	localparam logic [BANK_W-1:0] MODE_SEL_BASE = 2'h0;
	localparam logic [BANK_W-1:0] MODE_SEL_EXT = 2'h1;
	localparam int BL_POS = 0;
	localparam int BL_W = 3;
	localparam logic [BL_W-1:0] BL_CODE_2 = 3'h1;
	localparam logic [BL_W-1:0] BL_CODE_4 = 3'h2;
	localparam logic [BL_W-1:0] BL_CODE_8 = 3'h3;
	localparam logic [LEFT_W-1:0] PAIRS_BL2 = 3'h1;
	localparam logic [LEFT_W-1:0] PAIRS_BL4 = 3'h2;
	localparam logic [LEFT_W-1:0] PAIRS_BL8 = 3'h4;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [ADDR_W-1:0] MODE_RST = 13'h0002;
	localparam logic [ADDR_W-1:0] EXT_MODE_RST = 13'h0000;

	typedef enum logic [3:0] {
		PWR_ACTIVE = 4'h1,
		PWR_PRE_PD = 4'h2,
		PWR_ACT_PD = 4'h4,
		PWR_SELF_REF = 4'h8
	} dsci_power_e;

endpackage : dsci_pkg

// file: verilog/dsci_byte_lane.sv
// write capture of one byte lane on its own data strobe
module dsci_byte_lane
	import dsci_pkg::*;
(
	input wire logic strobe,
	input wire logic nrst,
	input wire logic [LANE_W-1:0] dqByte,
	input wire logic byteMask,
	input wire logic [PTR_W-1:0] readSlot,
	output logic [PTR_W-1:0] pairPtrGray,
	output logic [LANE_W-1:0] riseByte,
	output logic riseMask,
	output logic [LANE_W-1:0] fallByte,
	output logic fallMask
);

	logic [LANE_W-1:0] beatByte_q;
	logic beatMask_q;
	logic [LANE_W-1:0] slotRise_q [PAIR_SLOTS];
	logic [LANE_W-1:0] slotFall_q [PAIR_SLOTS];
	logic [PAIR_SLOTS-1:0] slotRiseMask_q;
	logic [PAIR_SLOTS-1:0] slotFallMask_q;
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] wrPtr_d;
	logic [PTR_W-1:0] gray_q;

	assign wrPtr_d = wrPtr_q + 2'h1;

	// mask sampled on the same edge as its data
	always_ff @(posedge strobe)
	begin
		beatByte_q <= dqByte;
		beatMask_q <= byteMask;
	end

	// pair completes on the falling edge, so nothing waits for a later strobe edge
	always_ff @(negedge strobe)
	begin
		slotRise_q[wrPtr_q] <= beatByte_q;
		slotRiseMask_q[wrPtr_q] <= beatMask_q;
		slotFall_q[wrPtr_q] <= dqByte;
		slotFallMask_q[wrPtr_q] <= byteMask;
	end

	always_ff @(negedge strobe)
	begin
		if (!nrst)
		begin
			wrPtr_q <= '0;
			gray_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			gray_q <= wrPtr_d ^ (wrPtr_d >> 1);
		end
	end

	// slots stay stable until the pointer wraps, four pairs later
	assign pairPtrGray = gray_q;
	assign riseByte = slotRise_q[readSlot];
	assign riseMask = slotRiseMask_q[readSlot];
	assign fallByte = slotFall_q[readSlot];
	assign fallMask = slotFallMask_q[readSlot];

endmodule : dsci_byte_lane

// file: verilog/dsci_command_interface.sv
// command decoder, bank state, power states and data path of the ddr device
//
// What this block does
// - sample commands on rising clock; data both edges
// - clock gate high enables, low disables operation
// - clock gate synchronous, except asynchronous output disable
// - gate drop enters power-down or self refresh
// - inputs ignored during power-down and self refresh
// - chip select high masks every command
// - decode commands from four active-low strobes
// - deselect or all strobes high is nop
// - bank select chooses target bank
// - address gives row, column, auto-precharge flag
// - precharge flag selects one or all banks
// - mode load: address operand, bank picks register
// - burst stop ends burst at any length
// - mask sampled with data masks storing
// - lower lane bits 0-7, upper lane 8-15
// - strobe edge-aligned on reads, captures writes
// - read latency three, or two and half
module dsci_command_interface
	import dsci_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clkGate,
	input wire logic chipSelectN,
	input wire logic rowStrobeN,
	input wire logic colStrobeN,
	input wire logic writeStrobeN,
	input wire logic [BANK_W-1:0] bankSelect,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic speedGrade333,
	input wire logic [DQ_W-1:0] dqIn,
	output logic [DQ_W-1:0] dqOut,
	output logic dqOeN,
	input wire logic lowerByteMask,
	input wire logic upperByteMask,
	input wire logic lowerDataStrobeIn,
	output logic lowerDataStrobeOut,
	output logic lowerDataStrobeOeN,
	input wire logic upperDataStrobeIn,
	output logic upperDataStrobeOut,
	output logic upperDataStrobeOeN,
	output logic [3:0] powerState,
	output logic [NUM_BANKS-1:0] bankOpen,
	output logic [ADDR_W-1:0] modeReg,
	output logic [ADDR_W-1:0] extModeReg,
	output logic [REFCNT_W-1:0] refreshCount
);

	// ****************************************
	// command sampling
	// ****************************************
	logic cke_q;
	logic ckePrev_q;
	logic [CMD_W-1:0] cmd_q;
	logic [BANK_W-1:0] bank_q;
	logic [ADDR_W-1:0] addr_q;
	dsci_power_e power_q;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			cke_q <= 1'b0;
			ckePrev_q <= 1'b0;
			cmd_q <= CMD_NOP;
			bank_q <= '0;
			addr_q <= '0;
		end
		else
		begin
			cke_q <= clkGate;
			ckePrev_q <= cke_q;
			cmd_q <= {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN};
			bank_q <= bankSelect;
			addr_q <= addr;
		end
	end

	// ****************************************
	// decode
	// ****************************************
	logic cmdLive;
	logic isModeLoad;
	logic isRefresh;
	logic isSelfEntry;
	logic isActivate;
	logic isRead;
	logic isWrite;
	logic isPrecharge;
	logic isStop;
	logic anyOpen;
	logic [NUM_BANKS-1:0] bankOpen_q;

	// select high yields a code outside every match, so it falls through as nop
	assign cmdLive = (power_q == PWR_ACTIVE) && ckePrev_q;
	assign isModeLoad = cmdLive && (cmd_q == CMD_MODE_LOAD);
	assign isRefresh = cmdLive && cke_q && (cmd_q == CMD_REFRESH);
	assign isSelfEntry = cmdLive && !cke_q && (cmd_q == CMD_REFRESH);
	assign isActivate = cmdLive && (cmd_q == CMD_ACTIVATE);
	assign isRead = cmdLive && (cmd_q == CMD_READ) && bankOpen_q[bank_q];
	assign isWrite = cmdLive && (cmd_q == CMD_WRITE) && bankOpen_q[bank_q];
	assign isPrecharge = cmdLive && (cmd_q == CMD_PRECHARGE);
	assign isStop = cmdLive && (cmd_q == CMD_STOP);
	assign anyOpen = |bankOpen_q;

	// ****************************************
	// power states
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			power_q <= PWR_ACTIVE;
		end
		else
		begin
			case (power_q)
				PWR_ACTIVE:
				begin
					if (ckePrev_q && !cke_q)
					begin
						if (anyOpen)
							power_q <= PWR_ACT_PD;
						else if (cmd_q == CMD_REFRESH)
							power_q <= PWR_SELF_REF;
						else
							power_q <= PWR_PRE_PD;
					end
				end
				PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF:
				begin
					// exit cycle carries no command
					if (cke_q)
						power_q <= PWR_ACTIVE;
				end
				default:
				begin
					power_q <= PWR_ACTIVE;
				end
			endcase
		end
	end

	logic [REFCNT_W-1:0] refreshCount_q;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			refreshCount_q <= '0;
		else if ((isRefresh || isSelfEntry) && !anyOpen)
			refreshCount_q <= refreshCount_q + 16'h0001;
	end

	// ****************************************
	// mode registers
	// ****************************************
	logic [ADDR_W-1:0] modeReg_q;
	logic [ADDR_W-1:0] extModeReg_q;
	logic [LEFT_W-1:0] burstPairs;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			modeReg_q <= MODE_RST;
			extModeReg_q <= EXT_MODE_RST;
		end
		else if (isModeLoad)
		begin
			if (bank_q == MODE_SEL_BASE)
				modeReg_q <= addr_q;
			else if (bank_q == MODE_SEL_EXT)
				extModeReg_q <= addr_q;
		end
	end

	always_comb
	begin
		case (modeReg_q[BL_POS +: BL_W])
			BL_CODE_2: burstPairs = PAIRS_BL2;
			BL_CODE_4: burstPairs = PAIRS_BL4;
			BL_CODE_8: burstPairs = PAIRS_BL8;
			default: burstPairs = PAIRS_BL4;
		endcase
	end

	function automatic logic [IDX_W-1:0] memIdx(
		input logic [BANK_W-1:0] b,
		input logic r,
		input logic [COL_W-1:0] c
	);
		return {b, r, c};
	endfunction : memIdx

	// ****************************************
	// read burst engine
	// ****************************************
	logic [LEFT_W-1:0] rdLeft_q;
	logic [COL_W-1:0] rdCol_q;
	logic [BANK_W-1:0] rdBank_q;
	logic rdRow_q;
	logic rdAuto_q;
	logic rdClose;
	logic [NUM_BANKS-1:0] rowBit_q;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			rdLeft_q <= '0;
			rdCol_q <= '0;
			rdBank_q <= '0;
			rdRow_q <= 1'b0;
			rdAuto_q <= 1'b0;
		end
		else if (isRead)
		begin
			rdLeft_q <= burstPairs;
			rdCol_q <= addr_q[COL_W-1:0];
			rdBank_q <= bank_q;
			rdRow_q <= rowBit_q[bank_q];
			rdAuto_q <= addr_q[AP_BIT];
		end
		else if (isStop)
		begin
			rdLeft_q <= '0;
			rdAuto_q <= 1'b0;
		end
		else if (rdLeft_q != '0)
		begin
			rdLeft_q <= rdLeft_q - 3'h1;
			rdCol_q <= rdCol_q + 3'h2;
		end
	end

	assign rdClose = rdAuto_q && (rdLeft_q == 3'h1) && !isRead;

	// ****************************************
	// write lanes
	// ****************************************
	logic [NUM_LANES-1:0] laneDone;
	logic [NUM_LANES-1:0][LANE_W-1:0] rdWordA;
	logic [NUM_LANES-1:0][LANE_W-1:0] rdWordB;
	logic [NUM_LANES-1:0] laneStrobe;
	logic [NUM_LANES-1:0] laneMask;
	logic [BANK_W-1:0] wrBank_q;
	logic wrRow_q;
	logic wrAuto_q;
	logic wrClose;

	assign laneStrobe = {upperDataStrobeIn, lowerDataStrobeIn};
	assign laneMask = {upperByteMask, lowerByteMask};

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			wrBank_q <= '0;
			wrRow_q <= 1'b0;
			wrAuto_q <= 1'b0;
		end
		else if (isWrite)
		begin
			wrBank_q <= bank_q;
			wrRow_q <= rowBit_q[bank_q];
			wrAuto_q <= addr_q[AP_BIT];
		end
		else if (wrClose)
		begin
			wrAuto_q <= 1'b0;
		end
	end

	assign wrClose = wrAuto_q && (&laneDone);

	generate
		for (genvar l = 0; l < NUM_LANES; l++)
		begin : gLane
			logic [PTR_W-1:0] gray;
			logic [PTR_W-1:0] graySync1_q;
			logic [PTR_W-1:0] graySync2_q;
			logic [PTR_W-1:0] wrBin;
			logic [PTR_W-1:0] rdPtr_q;
			logic [LEFT_W-1:0] left_q;
			logic [COL_W-1:0] col_q;
			logic [LANE_W-1:0] riseByte;
			logic [LANE_W-1:0] fallByte;
			logic riseMask;
			logic fallMask;
			logic havePair;
			logic [LANE_W-1:0] mem_q [MEM_DEPTH];

			dsci_byte_lane uLane (
				.strobe(laneStrobe[l]),
				.nrst(nrst),
				.dqByte(dqIn[l*LANE_W +: LANE_W]),
				.byteMask(laneMask[l]),
				.readSlot(rdPtr_q),
				.pairPtrGray(gray),
				.riseByte(riseByte),
				.riseMask(riseMask),
				.fallByte(fallByte),
				.fallMask(fallMask)
			);

			always_ff @(posedge mclk)
			begin
				graySync1_q <= gray;
				graySync2_q <= graySync1_q;
			end

			assign wrBin = {graySync2_q[1], graySync2_q[1] ^ graySync2_q[0]};
			assign havePair = (rdPtr_q != wrBin) && (left_q != '0);
			assign laneDone[l] = (left_q == '0);

			// strobe edges outside a write burst are skipped, not stored
			always_ff @(posedge mclk)
			begin
				if (!nrst)
				begin
					left_q <= '0;
					col_q <= '0;
					rdPtr_q <= wrBin;
				end
				else if (isWrite)
				begin
					left_q <= burstPairs;
					col_q <= addr_q[COL_W-1:0];
					rdPtr_q <= wrBin;
				end
				else if (isStop)
				begin
					left_q <= '0;
				end
				else if (havePair)
				begin
					left_q <= left_q - 3'h1;
					col_q <= col_q + 3'h2;
					rdPtr_q <= rdPtr_q + 2'h1;
				end
				else if (left_q == '0)
				begin
					rdPtr_q <= wrBin;
				end
			end

			always_ff @(posedge mclk)
			begin
				if (havePair)
				begin
					if (!riseMask)
						mem_q[memIdx(wrBank_q, wrRow_q, col_q)] <= riseByte;
					if (!fallMask)
						mem_q[memIdx(wrBank_q, wrRow_q, col_q + 3'h1)] <= fallByte;
				end
			end

			assign rdWordA[l] = mem_q[memIdx(rdBank_q, rdRow_q, rdCol_q)];
			assign rdWordB[l] = mem_q[memIdx(rdBank_q, rdRow_q, rdCol_q + 3'h1)];
		end
	endgenerate

	// ****************************************
	// bank state
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			bankOpen_q <= '0;
			rowBit_q <= '0;
		end
		else
		begin
			if (isActivate)
			begin
				bankOpen_q[bank_q] <= 1'b1;
				rowBit_q[bank_q] <= addr_q[0];
			end
			if (isPrecharge)
			begin
				if (addr_q[AP_BIT])
					bankOpen_q <= '0;
				else
					bankOpen_q[bank_q] <= 1'b0;
			end
			if (rdClose)
				bankOpen_q[rdBank_q] <= 1'b0;
			if (wrClose)
				bankOpen_q[wrBank_q] <= 1'b0;
		end
	end

	// ****************************************
	// read data out, both clock edges
	// ****************************************
	logic [DQ_W-1:0] pairA_q;
	logic [DQ_W-1:0] pairB_q;
	logic pairValid_q;
	logic [DQ_W-1:0] riseWord_q;
	logic riseValid_q;
	logic [DQ_W-1:0] holdB_q;
	logic holdValid_q;
	logic [DQ_W-1:0] fallWord_q;
	logic fallValid_q;
	logic driveNow;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			pairA_q <= '0;
			pairB_q <= '0;
			pairValid_q <= 1'b0;
		end
		else
		begin
			pairA_q <= rdWordA;
			pairB_q <= rdWordB;
			pairValid_q <= (rdLeft_q != '0);
		end
	end

	// half-cycle grade moves the first word onto the preceding falling edge
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			riseWord_q <= '0;
			riseValid_q <= 1'b0;
			holdB_q <= '0;
			holdValid_q <= 1'b0;
		end
		else
		begin
			riseWord_q <= speedGrade333 ? pairB_q : pairA_q;
			riseValid_q <= pairValid_q;
			holdB_q <= pairB_q;
			holdValid_q <= pairValid_q;
		end
	end

	always_ff @(negedge mclk)
	begin
		if (!nrst)
		begin
			fallWord_q <= '0;
			fallValid_q <= 1'b0;
		end
		else
		begin
			fallWord_q <= speedGrade333 ? pairA_q : holdB_q;
			fallValid_q <= speedGrade333 ? pairValid_q : holdValid_q;
		end
	end

	// raw gate pin: drivers drop without waiting for a clock edge
	assign driveNow = (mclk ? riseValid_q : fallValid_q) && clkGate;
	assign dqOut = mclk ? riseWord_q : fallWord_q;
	assign dqOeN = !driveNow;
	assign lowerDataStrobeOut = mclk;
	assign upperDataStrobeOut = mclk;
	assign lowerDataStrobeOeN = !driveNow;
	assign upperDataStrobeOeN = !driveNow;

	// ****************************************
	// status
	// ****************************************
	assign powerState = power_q;
	assign bankOpen = bankOpen_q;
	assign modeReg = modeReg_q;
	assign extModeReg = extModeReg_q;
	assign refreshCount = refreshCount_q;

endmodule : dsci_command_interface

// file: dv/dsci_command_interface_properties.sv
// concurrent checks on the pins of the ddr command interface
module dsci_command_interface_properties
	import dsci_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clkGate,
	input wire logic chipSelectN,
	input wire logic rowStrobeN,
	input wire logic colStrobeN,
	input wire logic writeStrobeN,
	input wire logic [BANK_W-1:0] bankSelect,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic speedGrade333,
	input wire logic dqOeN,
	input wire logic lowerDataStrobeOeN,
	input wire logic upperDataStrobeOeN,
	input wire logic [3:0] powerState,
	input wire logic [NUM_BANKS-1:0] bankOpen,
	input wire logic [ADDR_W-1:0] modeReg,
	input wire logic [ADDR_W-1:0] extModeReg,
	input wire logic [REFCNT_W-1:0] refreshCount
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [CMD_W-1:0] cmd;
	assign cmd = {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN};
	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// ********
	// read burst steps
	// ********
	// a stop right behind the read may cut the burst, so it is left out
	sequence s_read_taken;
		cmd == CMD_READ && clkGate && $past(clkGate) && bankOpen[bankSelect]
			&& powerState == PWR_ACTIVE ##1 cmd != CMD_STOP;
	endsequence
	sequence s_burst_start;
		dqOeN ##1 !dqOeN;
	endsequence
	a_read_lat_full: assert property (s_read_taken ##0 !speedGrade333 |-> ##2 s_burst_start)
		else $error("full latency read misplaced");
	a_read_lat_half: assert property (s_read_taken ##0 speedGrade333 |-> ##1 s_burst_start)
		else $error("half latency read misplaced");
	// ********
	// decode and state
	// ********
	a_oe_gate_off: assert property (!clkGate |-> dqOeN)
		else $error("data driven with gate low");
	a_strobe_oe_pair: assert property (lowerDataStrobeOeN == dqOeN && upperDataStrobeOeN == dqOeN)
		else $error("strobe enable differs from data enable");
	a_bank_opens: assert property (|(bankOpen & ~$past(bankOpen)) |->
		$past(cmd, 2) == CMD_ACTIVATE && bankOpen[$past(bankSelect, 2)])
		else $error("bank opened without activate");
	a_mode_base: assert property ($changed(modeReg) |-> $past(cmd, 2) == CMD_MODE_LOAD
		&& $past(bankSelect, 2) == MODE_SEL_BASE && modeReg == $past(addr, 2))
		else $error("base mode changed wrongly");
	a_mode_ext: assert property ($changed(extModeReg) |-> $past(cmd, 2) == CMD_MODE_LOAD
		&& $past(bankSelect, 2) == MODE_SEL_EXT && extModeReg == $past(addr, 2))
		else $error("extended mode changed wrongly");
	a_refresh_code: assert property ($changed(refreshCount) |-> $past(cmd, 2) == CMD_REFRESH
		&& refreshCount == $past(refreshCount) + 1)
		else $error("refresh count moved wrongly");
	a_gate_idle_entry: assert property ($fell(clkGate) && bankOpen == '0
		&& powerState == PWR_ACTIVE |-> ##[1:2] powerState inside {PWR_PRE_PD, PWR_SELF_REF})
		else $error("idle gate drop missed power-down");
	a_gate_open_entry: assert property ($fell(clkGate) && bankOpen != '0
		&& powerState == PWR_ACTIVE |-> ##[1:2] powerState == PWR_ACT_PD)
		else $error("open gate drop missed active power-down");
	a_sleep_frozen: assert property (powerState != PWR_ACTIVE && $past(powerState) != PWR_ACTIVE
		|-> $stable(bankOpen) && $stable(modeReg))
		else $error("state moved while asleep");
	a_wake_on_gate: assert property (powerState != PWR_ACTIVE && clkGate
		|-> ##[1:2] powerState == PWR_ACTIVE)
		else $error("no wake after gate rise");
endmodule : dsci_command_interface_properties

// file: dv/dsci_ctrl_model.sv
// write side of the memory controller: strobes, data and masks
module dsci_ctrl_model
	import dsci_pkg::*;
(
	output logic [DQ_W-1:0] dqIn,
	output logic lowerDataStrobeIn,
	output logic upperDataStrobeIn,
	output logic lowerByteMask,
	output logic upperByteMask
);
	timeunit 1ns;
	timeprecision 100ps;
	// strobes stand low between frames
	initial
	begin
		dqIn = '0;
		{lowerDataStrobeIn, upperDataStrobeIn, lowerByteMask, upperByteMask} = '0;
	end
	// one 32 ns strobe period per word pair, each word set 8 ns before its edge
	task automatic send_pair(input logic [DQ_W-1:0] d0, input logic [DQ_W-1:0] d1,
		input logic [NUM_LANES-1:0] m0, input logic [NUM_LANES-1:0] m1);
		dqIn = d0;
		{upperByteMask, lowerByteMask} = m0;
		#8 {lowerDataStrobeIn, upperDataStrobeIn} = 2'b11;
		#8 dqIn = d1;
		{upperByteMask, lowerByteMask} = m1;
		#8 {lowerDataStrobeIn, upperDataStrobeIn} = 2'b00;
		// released: inverse of last value, 4 ns after the falling edge and 4 ns before the next pair may start
		#4 dqIn = ~d1;
		{upperByteMask, lowerByteMask} = ~m1;
		#4;
	endtask : send_pair
endmodule : dsci_ctrl_model

// file: dv/dsci_command_interface_test.sv
// self-checking bench of the ddr command interface
module dsci_command_interface_test
	import dsci_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic clkGate = 1'b1;
	logic speedGrade333 = 1'b0;
	logic [CMD_W-1:0] cmd = CMD_NOP;
	logic [BANK_W-1:0] bankSelect = '0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DQ_W-1:0] dqIn, dqOut, ctlDq;
	logic dqOeN, lsOut, lsOeN, usOut, usOeN, lsIn, usIn, ctlLs, ctlUs, lMask, uMask;
	logic [3:0] powerState;
	logic [NUM_BANKS-1:0] bankOpen;
	logic [ADDR_W-1:0] modeReg, extModeReg;
	logic [REFCNT_W-1:0] refreshCount;
	logic [DQ_W-1:0] pat [4];
	// {command, bank, address, banks open after}
	logic [22:0] steps [7] = '{{4'hb, 2'h0, 13'h0000, 4'h0}, {CMD_ACTIVATE, 2'h0, 13'h0000, 4'h1},
		{CMD_ACTIVATE, 2'h1, 13'h0000, 4'h3}, {CMD_ACTIVATE, 2'h2, 13'h0000, 4'h7},
		{CMD_ACTIVATE, 2'h3, 13'h0000, 4'hf}, {CMD_PRECHARGE, 2'h0, 13'h0000, 4'h4},
		{CMD_PRECHARGE, 2'h1, 13'h0400, 4'h0}};
	int mismatches = 0;
	int nTests = 0;
	always #20 mclk = ~mclk;
	// wire level: device drives only while its enable is low
	assign dqIn = dqOeN ? ctlDq : dqOut;
	assign lsIn = lsOeN ? ctlLs : lsOut;
	assign usIn = usOeN ? ctlUs : usOut;
	dsci_ctrl_model ctl (.dqIn(ctlDq), .lowerDataStrobeIn(ctlLs), .upperDataStrobeIn(ctlUs),
		.lowerByteMask(lMask), .upperByteMask(uMask));
	dsci_command_interface dut (.mclk(mclk), .nrst(nrst), .clkGate(clkGate),
		.chipSelectN(cmd[3]), .rowStrobeN(cmd[2]), .colStrobeN(cmd[1]), .writeStrobeN(cmd[0]),
		.bankSelect(bankSelect), .addr(addr), .speedGrade333(speedGrade333), .dqIn(dqIn),
		.dqOut(dqOut), .dqOeN(dqOeN), .lowerByteMask(lMask), .upperByteMask(uMask),
		.lowerDataStrobeIn(lsIn), .lowerDataStrobeOut(lsOut), .lowerDataStrobeOeN(lsOeN),
		.upperDataStrobeIn(usIn), .upperDataStrobeOut(usOut), .upperDataStrobeOeN(usOeN),
		.powerState(powerState), .bankOpen(bankOpen), .modeReg(modeReg),
		.extModeReg(extModeReg), .refreshCount(refreshCount));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic issue(input logic [CMD_W-1:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a);
		@(posedge mclk);
		#2 cmd = c;
		bankSelect = b;
		addr = a;
	endtask : issue
	task automatic nop(input int n);
		issue(CMD_NOP, 2'h0, 13'h0000);
		repeat (n) @(posedge mclk);
		#2;
	endtask : nop
	task automatic run(input int lo, input int hi);
		for (int i = lo; i <= hi; i++)
		begin
			issue(steps[i][22:19], steps[i][18:17], steps[i][16:4]);
			nop(2);
			chk("banks open", bankOpen, steps[i][3:0]);
		end
	endtask : run
	task automatic wr(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a, input logic [7:0] m);
		issue(CMD_WRITE, b, a);
		// first strobe edge only once the lanes are armed
		nop(1);
		for (int i = 0; i < 4; i += 2)
			ctl.send_pair(pat[i], pat[i+1], m[2*i+:2], m[2*i+2+:2]);
		nop(6);
	endtask : wr
	task automatic rd(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
		input logic [DQ_W-1:0] e [4]);
		issue(CMD_READ, b, a);
		nop(2);
		for (int i = 0; i < 4; i++)
		begin
			if ((i + speedGrade333) % 2 == 0)
				@(posedge mclk);
			else
				@(negedge mclk);
			#5 chk("read word", dqOut, e[i]);
			chk("read enable", dqOeN, 1'b0);
			chk("read strobe", {lsOut, usOut}, ((i + speedGrade333) % 2 == 0) ? 2'b11 : 2'b00);
		end
		nop(2);
	endtask : rd
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial
	begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial
	begin
		// strobe pointers only clear on strobe edges inside reset
		fork
			begin
				#4;
				repeat (2) ctl.send_pair('0, '0, '0, '0);
			end
			repeat (16) @(posedge mclk);
		join
		#2 nrst = 1'b1;
		chk("reset state", {powerState, bankOpen, dqOeN, refreshCount},
			{PWR_ACTIVE, 4'h0, 1'b1, 16'h0000});
		chk("reset modes", {modeReg, extModeReg}, {MODE_RST, EXT_MODE_RST});
		issue(CMD_MODE_LOAD, MODE_SEL_EXT, 13'h0055);
		nop(0);
		issue(CMD_MODE_LOAD, MODE_SEL_BASE, {10'h000, BL_CODE_4});
		nop(2);
		chk("mode regs", {modeReg, extModeReg}, {10'h000, BL_CODE_4, 13'h0055});
		run(0, 4);
		pat = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
		wr(2'h1, 13'h0006, 8'h00);
		pat = '{16'haaaa, 16'hbbbb, 16'hcccc, 16'hdddd};
		wr(2'h1, 13'h0006, 8'h24);
		for (int g = 0; g < 2; g++)
		begin
			speedGrade333 = g[0];
			rd(2'h1, 13'h0006, '{16'haaaa, 16'hbb22, 16'h33cc, 16'hdddd});
		end
		rd(2'h1, 13'h0406, '{16'haaaa, 16'hbb22, 16'h33cc, 16'hdddd});
		chk("read auto precharge", bankOpen, 4'hd);
		wr(2'h3, 13'h0400, 8'h00);
		chk("write auto precharge", bankOpen, 4'h5);
		issue(CMD_READ, 2'h2, 13'h0400);
		issue(CMD_STOP, 2'h0, 13'h0000);
		nop(6);
		chk("stop keeps row", bankOpen, 4'h5);
		// gate drop in mid-burst must silence the drivers before any clock edge
		issue(CMD_READ, 2'h2, 13'h0000);
		nop(3);
		@(posedge mclk);
		#2 clkGate = 1'b0;
		#1 chk("gate cuts drivers", {dqOeN, lsOeN, usOeN}, 3'h7);
		@(posedge mclk);
		#2 clkGate = 1'b1;
		nop(4);
		chk("gate read wake", {powerState, bankOpen}, {PWR_ACTIVE, 4'h5});
		run(5, 6);
		issue(CMD_REFRESH, 2'h0, 13'h0000);
		nop(2);
		chk("auto refresh", refreshCount, 16'h0001);
		issue(CMD_REFRESH, 2'h0, 13'h0000);
		clkGate = 1'b0;
		nop(2);
		chk("self refresh", {powerState, refreshCount}, {PWR_SELF_REF, 16'h0002});
		clkGate = 1'b1;
		nop(3);
		for (int k = 0; k < 2; k++)
		begin
			chk("awake", powerState, PWR_ACTIVE);
			clkGate = 1'b0;
			issue(CMD_PRECHARGE, 2'h0, 13'h0400);
			nop(2);
			chk("power down", powerState, k ? PWR_ACT_PD : PWR_PRE_PD);
			chk("asleep", {bankOpen, dqOeN}, {k[0] ? 4'h1 : 4'h0, 1'b1});
			clkGate = 1'b1;
			nop(3);
			if (k == 0)
				issue(CMD_ACTIVATE, 2'h0, 13'h0000);
			nop(2);
		end
		end_sim();
	end
endmodule : dsci_command_interface_test
bind dsci_command_interface dsci_command_interface_properties chk (.mclk, .nrst, .clkGate,
	.chipSelectN, .rowStrobeN, .colStrobeN, .writeStrobeN, .bankSelect, .addr, .speedGrade333,
	.dqOeN, .lowerDataStrobeOeN, .upperDataStrobeOeN, .powerState, .bankOpen, .modeReg,
	.extModeReg, .refreshCount);
